// [logic/sdos_dev.sv]
// Output stage of the speech decoder: de-emphasis, upscale, truncate.
// Assumes upstream delivers synthesis samples in index order and the
// far end keeps the reset and parameter pacing of the link.
// Function
// - De-emphasis: input plus rounded feedback times 28180
// - Feedback state kept across frames, zero at reset
// - Double each sample with 16-bit saturation
// - Clear three low bits of upscaled sample
// - Output is sign, twelve valid, three zeros
// - A-law coder fed sample shifted right three
// - Tester asserts reset before first frame; sdos_host skips it when HOMING_EN is set
// - Reset input only used without homing
// - One output sample every 8 kHz period
// - Source sends 76 parameters per 20 ms
// - All words 16 bits, justified per type
// - With homing first frame may be arbitrary
// - Without homing every frame after reset exact
`timescale 1ns/1ps
`default_nettype none
module sdos_dev
   import sdos_pkg::*;
#(
   parameter int SAMPLE_DIV = SAMPLE_CYCLES,
   parameter bit HOMING_EN  = 1'b0
) (
   // Link to tester and upstream
   sdos_if.dev              link,
   // Parameter words towards upstream decoder
   output var  logic [15:0] o_param_data,
   output var  logic        o_param_valid,
   input  wire logic        i_param_ready,
   // PCM towards sink
   output var  logic [15:0] o_pcm,
   output var  logic [7:0]  o_alaw,
   output var  logic        o_pcm_valid,
   // Status
   output var  logic        o_frame_start,
   output var  logic        o_bit_exact
);
   typedef logic signed [15:0] sdos_s16_t;

   function automatic sdos_s16_t sat_add(sdos_s16_t a, sdos_s16_t b);
      logic signed [16:0] s;
      s = 17'(a) + 17'(b);
      if (s > 17'(S16_MAX)) begin
         return S16_MAX;
      end else if (s < 17'(S16_MIN)) begin
         return S16_MIN;
      end
      return s[15:0];
   endfunction : sat_add

   function automatic sdos_s16_t mult_r(sdos_s16_t a, sdos_s16_t b);
      logic signed [31:0] p;
      p = 32'(a) * 32'(b);
      if (a == S16_MIN && b == S16_MIN) begin
         return S16_MAX;
      end
      p = p + ROUND_HALF;
      return 16'(p >>> ROUND_SHIFT);
   endfunction : mult_r

   localparam int DIV_W = $clog2(SAMPLE_DIV);
   localparam int IDX_W = $clog2(FRAME_SAMPLES);
   localparam int PAR_W = $clog2(FRAME_PARAMS + 1);

   logic clk;
   logic rst;
   assign clk = link.clk;
   assign rst = link.rst;

   // Sample rate divider
   logic [DIV_W-1:0] div_d, div_q;
   logic             tick;
   always_comb begin
      tick  = (div_q == DIV_W'(SAMPLE_DIV - 1));
      div_d = tick ? '0 : div_q + 1'b1;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_q <= '0;
      end else begin
         div_q <= div_d;
      end
   end

   // Codec reset only honoured when homing is absent
   logic soft_rst;
   assign soft_rst = link.codec_reset_in && !HOMING_EN;

   // One-deep sample holding register
   logic        hold_v_d, hold_v_q;
   sdos_s16_t   hold_d, hold_q;
   logic        take;
   assign link.syn_ready = !hold_v_q || tick;
   assign take = link.syn_valid && link.syn_ready;
   always_comb begin
      hold_v_d = hold_v_q;
      hold_d   = hold_q;
      if (tick) begin
         hold_v_d = 1'b0;
      end
      if (take) begin
         hold_v_d = 1'b1;
         hold_d   = link.synth_sample_in;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_v_q <= 1'b0;
         hold_q   <= MSR_RESET;
      end else begin
         hold_v_q <= hold_v_d;
         hold_q   <= hold_d;
      end
   end

   // Datapath
   sdos_s16_t deemph, dbl;
   // Feedback state declared ahead of the datapath that reads it
   sdos_s16_t msr_d, msr_q;
   logic [15:0] trunc;
   logic        emit;
   assign emit   = tick && hold_v_q;
   assign deemph = sat_add(hold_q, mult_r(msr_q, DEEMPH_COEF));
   assign dbl    = sat_add(deemph, deemph);
   // Low bits cleared; sign and valid bits sit left-justified
   assign trunc  = {dbl[15:TRUNC_BITS], TRUNC_BITS'(0)};

   // Filter state, output and frame index
   logic [15:0]      pcm_d, pcm_q;
   logic             pv_d, pv_q, fs_d, fs_q, ur_d, ur_q;
   logic [IDX_W-1:0] idx_d, idx_q;
   logic             frame_end;
   assign frame_end = emit && (idx_q == IDX_W'(FRAME_SAMPLES - 1));
   always_comb begin
      msr_d = msr_q;
      pcm_d = pcm_q;
      idx_d = idx_q;
      pv_d  = tick;
      fs_d  = emit && (idx_q == '0);
      ur_d  = tick && !hold_v_q;
      if (emit) begin
         msr_d = deemph;
         pcm_d = trunc;
         idx_d = frame_end ? '0 : idx_q + 1'b1;
      end
      if (soft_rst) begin
         msr_d = MSR_RESET;
         idx_d = '0;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         msr_q <= MSR_RESET;
         pcm_q <= PCM_RESET;
         idx_q <= '0;
         pv_q  <= 1'b0;
         fs_q  <= 1'b0;
         ur_q  <= 1'b0;
      end else begin
         msr_q <= msr_d;
         pcm_q <= pcm_d;
         idx_q <= idx_d;
         pv_q  <= pv_d;
         fs_q  <= fs_d;
         ur_q  <= ur_d;
      end
   end

   // A-law code tracks the PCM register cycle for cycle
   sdos_alaw u_alaw (
      .i_core_clk (clk),
      .i_rst      (rst),
      .i_en       (emit),
      .i_law_sel  (ALAW_LAW_SEL),
      .i_lin      (dbl[15:TRUNC_BITS]),
      .o_code     (link.alaw_data)
   );

   // Parameter pass-through and per-frame count
   logic [15:0]      par_d, par_q;
   logic             parv_d, parv_q, ps_d, ps_q;
   logic [PAR_W-1:0] pcnt_d, pcnt_q;
   logic             par_take;
   assign link.par_ready = !parv_q || i_param_ready;
   assign par_take = link.par_valid && link.par_ready;
   always_comb begin
      par_d  = par_q;
      parv_d = parv_q && !i_param_ready;
      pcnt_d = pcnt_q;
      ps_d   = 1'b0;
      if (par_take) begin
         par_d  = link.par_data;
         parv_d = 1'b1;
         if (pcnt_q != PAR_W'(FRAME_PARAMS)) begin
            pcnt_d = pcnt_q + 1'b1;
         end
      end
      if (frame_end) begin
         // Short frames flagged; pacing is the source's duty
         ps_d   = (pcnt_q < PAR_W'(FRAME_PARAMS));
         pcnt_d = '0;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         par_q  <= '0;
         parv_q <= 1'b0;
         pcnt_q <= '0;
         ps_q   <= 1'b0;
      end else begin
         par_q  <= par_d;
         parv_q <= parv_d;
         pcnt_q <= pcnt_d;
         ps_q   <= ps_d;
      end
   end

   // First frame after reset is untrusted when homing is used
   logic exact_d, exact_q;
   always_comb begin
      exact_d = exact_q;
      if (frame_end) begin
         exact_d = 1'b1;
      end
      if (soft_rst) begin
         exact_d = 1'b1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         exact_q <= !HOMING_EN;
      end else begin
         exact_q <= exact_d;
      end
   end

   assign link.pcm_data    = pcm_q;
   assign link.pcm_valid   = pv_q;
   assign link.frame_start = fs_q;
   assign link.underrun    = ur_q;
   assign link.param_short = ps_q;
   assign o_param_data     = par_q;
   assign o_param_valid    = parv_q;
   assign o_pcm            = pcm_q;
   assign o_alaw           = link.alaw_data;
   assign o_pcm_valid      = pv_q;
   assign o_frame_start    = fs_q;
   assign o_bit_exact      = exact_q;
endmodule : sdos_dev
`default_nettype wire

// [inc/sdos_pkg.sv]
// Constants shared by both ends of the speech output stage link.
// Assumes one 250 MHz core clock on both ends.
package sdos_pkg;
   // Clock and rates
   localparam int CLK_PERIOD_PS      = 4000;
   localparam int SAMPLE_PERIOD_US   = 125;
   localparam int SAMPLE_CYCLES      =
      (SAMPLE_PERIOD_US * 1000 * 1000) / CLK_PERIOD_PS;
   localparam int FRAME_PERIOD_MS    = 20;
   // Frame layout
   localparam int FRAME_SAMPLES      = 160;
   localparam int FRAME_PARAMS       = 76;
   localparam int WORD_W             = 16;
   // Arithmetic
   localparam logic signed [15:0] DEEMPH_COEF = 16'sh6E14;
   localparam logic signed [15:0] S16_MAX     = 16'sh7FFF;
   localparam logic signed [15:0] S16_MIN     = 16'sh8000;
   localparam logic signed [31:0] ROUND_HALF  = 32'sh0000_4000;
   localparam int ROUND_SHIFT        = 15;
   localparam int TRUNC_BITS         = 3;
   localparam logic ALAW_LAW_SEL     = 1'b1;
   localparam logic [7:0] ALAW_XOR   = 8'h55;
   // Reset values
   localparam logic signed [15:0] MSR_RESET = 16'sh0000;
   localparam logic [15:0] PCM_RESET        = 16'h0000;
   // Host reset pulse length
   localparam int CODEC_RESET_CYCLES = 4;
endpackage : sdos_pkg

// [inc/sdos_if.sv]
// Link between the tester/upstream end and the output stage.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ps
`default_nettype none
interface sdos_if (
   input wire logic clk,
   input wire logic rst
);
   logic        codec_reset_in;
   logic [15:0] par_data;
   logic        par_valid;
   logic        par_ready;
   logic [15:0] synth_sample_in;
   logic        syn_valid;
   logic        syn_ready;
   logic [15:0] pcm_data;
   logic [7:0]  alaw_data;
   logic        pcm_valid;
   logic        frame_start;
   logic        underrun;
   logic        param_short;

   modport dev (
      input  clk, rst, codec_reset_in, par_data, par_valid,
             synth_sample_in, syn_valid,
      output par_ready, syn_ready, pcm_data, alaw_data, pcm_valid,
             frame_start, underrun, param_short
   );
   modport host (
      input  clk, rst, par_ready, syn_ready, pcm_data, alaw_data,
             pcm_valid, frame_start, underrun, param_short,
      output codec_reset_in, par_data, par_valid, synth_sample_in,
             syn_valid
   );
endinterface : sdos_if
`default_nettype wire

// [logic/sdos_alaw.sv]
// Linear-to-A-law compressor with registered output.
// Assumes a 13-bit two's complement input and a one-cycle enable.
`timescale 1ns/1ps
`default_nettype none
module sdos_alaw
   import sdos_pkg::*;
(
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   // Sample in
   input  wire logic        i_en,
   input  wire logic        i_law_sel,
   input  wire logic [12:0] i_lin,
   // Code out
   output var  logic [7:0]  o_code
);
   logic [11:0] mag;
   logic [2:0]  seg;
   logic [3:0]  quant;
   logic [7:0]  code_d;
   logic [7:0]  code_q;

   always_comb begin
      // Ones complement keeps the negative range symmetric
      mag   = i_lin[12] ? ~i_lin[11:0] : i_lin[11:0];
      seg   = 3'h0;
      quant = mag[4:1];
      for (int b = 5; b < 12; b++) begin
         if (mag[b]) begin
            seg   = 3'(b - 4);
            quant = mag[b-1 -: 4];
         end
      end
      code_d = code_q;
      if (i_en && i_law_sel) begin
         code_d = {~i_lin[12], seg, quant} ^ ALAW_XOR;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         code_q <= ALAW_XOR;
      end else begin
         code_q <= code_d;
      end
   end

   assign o_code = code_q;
endmodule : sdos_alaw
`default_nettype wire

// [logic/sdos_host.sv]
// Tester/upstream end: reset pulse, parameter and sample sourcing.
// Assumes the user side paces 76 parameters per frame interval.
`timescale 1ns/1ps
`default_nettype none
module sdos_host
   import sdos_pkg::*;
#(
   parameter bit HOMING_EN = 1'b0
) (
   // Link to output stage
   sdos_if.host             link,
   // Control
   input  wire logic        i_start,
   output var  logic        o_running,
   // Parameter words in
   input  wire logic [15:0] i_param_data,
   input  wire logic        i_param_valid,
   output var  logic        o_param_ready,
   // Synthesis samples in
   input  wire logic [15:0] i_synth_data,
   input  wire logic        i_synth_valid,
   output var  logic        o_synth_ready,
   // PCM and status out
   output var  logic [15:0] o_pcm,
   output var  logic [7:0]  o_alaw,
   output var  logic        o_pcm_valid,
   output var  logic        o_underrun,
   output var  logic        o_param_short
);
   typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_RUN} sdos_state_e;
   localparam int RC_W = $clog2(CODEC_RESET_CYCLES + 1);

   logic clk;
   logic rst;
   assign clk = link.clk;
   assign rst = link.rst;

   sdos_state_e     st_d, st_q;
   logic [RC_W-1:0] rc_d, rc_q;
   logic            crst_d, crst_q;
   always_comb begin
      st_d   = st_q;
      rc_d   = rc_q;
      crst_d = 1'b0;
      case (st_q)
         ST_IDLE: begin
            if (i_start) begin
               // With homing the reset pin is left idle
               st_d = HOMING_EN ? ST_RUN : ST_RESET;
               rc_d = RC_W'(CODEC_RESET_CYCLES);
            end
         end
         ST_RESET: begin
            crst_d = 1'b1;
            rc_d   = rc_q - 1'b1;
            if (rc_q == RC_W'(1)) begin
               st_d = ST_RUN;
            end
         end
         default: begin
            st_d = ST_RUN;
         end
      endcase
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q   <= ST_IDLE;
         rc_q   <= '0;
         crst_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         rc_q   <= rc_d;
         crst_q <= crst_d;
      end
   end

   // Traffic is held off until the last cycle of the reset pulse, or only until start when homing is used
   logic run;
   assign run                 = (st_q == ST_RUN);
   assign link.codec_reset_in = crst_q;
   assign link.par_data       = i_param_data;
   assign link.par_valid      = i_param_valid && run;
   assign o_param_ready       = link.par_ready && run;
   assign link.synth_sample_in = i_synth_data;
   assign link.syn_valid      = i_synth_valid && run;
   assign o_synth_ready       = link.syn_ready && run;
   assign o_running           = run;
   assign o_pcm               = link.pcm_data;
   assign o_alaw              = link.alaw_data;
   assign o_pcm_valid         = link.pcm_valid;
   assign o_underrun          = link.underrun;
   assign o_param_short       = link.param_short;
endmodule : sdos_host
`default_nettype wire

// [dv/sdos_props.sv]
// Link checker for the speech output stage.
// Assumes one clock, an async active-high reset and SAMPLE_DIV as in dev.
`timescale 1ns/1ps
`default_nettype none
module sdos_props
   import sdos_pkg::*;
#(
   parameter int SAMPLE_DIV = SAMPLE_CYCLES
) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Watched link signals
   input wire logic        codec_reset_in,
   input wire logic [15:0] pcm_data,
   input wire logic [7:0]  alaw_data,
   input wire logic        pcm_valid,
   input wire logic        frame_start,
   input wire logic        underrun
);
   logic [15:0] gap_q, gap_d;
   logic        have_q, have_d;
   logic [7:0]  emit_q, emit_d;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Codec reset restarts the frame count and the period check, divider phase may move
   always_comb begin
      gap_d  = pcm_valid ? 16'h0001 : gap_q + 16'h0001;
      have_d = codec_reset_in ? 1'b0 : (pcm_valid | have_q);
      emit_d = emit_q;
      if (codec_reset_in)
         emit_d = 8'h00;
      else if (pcm_valid && !underrun)
         emit_d = (int'(emit_q) == FRAME_SAMPLES - 1) ? 8'h00 : emit_q + 8'h01;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gap_q  <= 16'h0000;
         have_q <= 1'b0;
         emit_q <= 8'h00;
      end else begin
         gap_q  <= gap_d;
         have_q <= have_d;
         emit_q <= emit_d;
      end
   end

   AST_LOW_ZERO:
      assert property (pcm_valid |-> pcm_data[2:0] == 3'h0)
      else $error("pcm low bits set");
   AST_PERIOD:
      assert property (pcm_valid && have_q |-> int'(gap_q) == SAMPLE_DIV)
      else $error("pcm pulse spacing wrong");
   AST_HOLD:
      assert property (pcm_valid && underrun |-> $stable(pcm_data))
      else $error("pcm changed on underrun");
   AST_FS_VALID:
      assert property (frame_start |-> pcm_valid && !underrun)
      else $error("frame start without sample");
   AST_UR_VALID:
      assert property (underrun |-> pcm_valid)
      else $error("underrun without pcm pulse");
   AST_FRAME_LEN:
      assert property (pcm_valid && !underrun && !codec_reset_in
                       |-> frame_start == (emit_q == 8'h00))
      else $error("frame start not every 160 samples");
   AST_ALAW_SIGN:
      assert property (pcm_valid && !underrun
                       |-> alaw_data[7] == (!pcm_data[15] ^ ALAW_XOR[7]))
      else $error("alaw sign wrong");
   AST_ALAW_ZERO:
      assert property (pcm_valid && !underrun && pcm_data == 16'h0000
                       |-> alaw_data == (8'h80 ^ ALAW_XOR))
      else $error("alaw code of zero wrong");
   AST_CRST_LEN:
      assert property ($rose(codec_reset_in) |-> codec_reset_in [*4]
                       ##1 !codec_reset_in)
      else $error("codec reset pulse length wrong");

   cover property (frame_start);
   cover property (pcm_valid && underrun);
   cover property (pcm_valid && pcm_data == 16'h7FF8);
endmodule : sdos_props
`default_nettype wire

// [dv/sdos_tb_top.sv]
// Bench: host and output stage on one link, plus a fault link where the
// bench plays a tester that sends no parameters to a homing stage.
// Assumes the package, interface, both ends and the checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module sdos_tb_top
   import sdos_pkg::*;
;
   localparam int DIV = 8;
   logic        i_core_clk, i_rst, start, par_v, syn_v, dev_pr, feeding;
   logic [15:0] par_d, syn_d, msr, d, u, last_pcm, h_pcm, dev_pd;
   logic [7:0]  h_alaw;
   logic        running, h_par_rdy, h_syn_rdy, h_pv, h_und, h_short;
   logic        dev_pv, dev_fs, dev_be, flt_be, flt_short_seen;
   logic [15:0] eq[$], pq[$];
   logic [7:0]  aq[$];
   int          n_errors, total_checks, idx;
   logic [15:0] corners[8] = '{16'h7FFF, 16'h7FFF, 16'h7FFF, 16'h8000,
                               16'h8000, 16'h0000, 16'hFFFF, 16'h0001};

   sdos_if link (.clk(i_core_clk), .rst(i_rst));
   sdos_if flt_link (.clk(i_core_clk), .rst(i_rst));
   sdos_host #(.HOMING_EN(1'b0)) sdos_host_i (.link(link), .i_start(start),
      .o_running(running), .i_param_data(par_d), .i_param_valid(par_v),
      .o_param_ready(h_par_rdy), .i_synth_data(syn_d),
      .i_synth_valid(syn_v), .o_synth_ready(h_syn_rdy), .o_pcm(h_pcm),
      .o_alaw(h_alaw), .o_pcm_valid(h_pv), .o_underrun(h_und),
      .o_param_short(h_short));
   sdos_dev #(.SAMPLE_DIV(DIV), .HOMING_EN(1'b0)) sdos_dev_i (.link(link),
      .o_param_data(dev_pd), .o_param_valid(dev_pv), .i_param_ready(dev_pr),
      .o_pcm(), .o_alaw(), .o_pcm_valid(), .o_frame_start(dev_fs),
      .o_bit_exact(dev_be));
   sdos_dev #(.SAMPLE_DIV(DIV), .HOMING_EN(1'b1)) flt_sdos_dev_i (
      .link(flt_link), .o_param_data(), .o_param_valid(),
      .i_param_ready(1'b1), .o_pcm(), .o_alaw(), .o_pcm_valid(),
      .o_frame_start(), .o_bit_exact(flt_be));
   sdos_props #(.SAMPLE_DIV(DIV)) sdos_props_i (.clk(link.clk),
      .rst(link.rst), .codec_reset_in(link.codec_reset_in),
      .pcm_data(link.pcm_data), .alaw_data(link.alaw_data),
      .pcm_valid(link.pcm_valid), .frame_start(link.frame_start),
      .underrun(link.underrun));

   function automatic logic [15:0] add16(input logic [15:0] a, b);
      logic signed [16:0] s;
      s = $signed({a[15], a}) + $signed({b[15], b});
      if (s > 17'sh07FFF) return 16'h7FFF;
      if (s < 17'sh18000) return 16'h8000;
      return s[15:0];
   endfunction : add16

   function automatic logic [15:0] mulr(input logic [15:0] a, b);
      logic signed [31:0] p;
      p = ($signed(a) * $signed(b) + 32'sh4000) >>> 15;
      return (p > 32'sh7FFF) ? 16'h7FFF : p[15:0];
   endfunction : mulr

   function automatic logic [7:0] alaw(input logic [12:0] x);
      logic [11:0] ix;
      logic [2:0]  e;
      ix = (x[12] ? ~x[11:0] : x[11:0]) >> 1;
      e = (ix > 15) ? 3'h1 : 3'h0;
      while (ix > 31) begin
         ix = ix >> 1;
         e = e + 3'h1;
      end
      return {~x[12], e, ix[3:0]} ^ ALAW_XOR;
   endfunction : alaw

   task automatic chk_word(input string what, input logic [15:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word

   task automatic chk_bit(input string what, input logic exp, got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict

   task automatic tmo(input string what);
      n_errors++;
      $display("[FAIL] %s expected handshake seen timeout", what);
      print_verdict();
   endtask : tmo

   // Random gaps starve the stage so underrun pulses get exercised
   task automatic feed(input int n, input bit corner);
      int k, w;
      for (k = 0; k < n; k++) begin
         syn_d <= corner ? corners[k] : 16'($urandom);
         syn_v <= 1'b1;
         w = 0;
         @(negedge i_core_clk);
         while (h_syn_rdy !== 1'b1) begin
            if (++w > 4 * DIV) tmo("sample accept");
            @(negedge i_core_clk);
         end
         @(posedge i_core_clk);
         if (!corner && $urandom_range(15) == 0) begin
            syn_v <= 1'b0;
            repeat (3 * DIV) @(posedge i_core_clk);
         end
      end
   endtask : feed

   task automatic params();
      int w;
      while (feeding) begin
         par_d <= {10'h000, 6'($urandom)};
         par_v <= 1'b1;
         w = 0;
         @(negedge i_core_clk);
         while (h_par_rdy !== 1'b1) begin
            if (++w > 40) tmo("param accept");
            @(negedge i_core_clk);
         end
         @(posedge i_core_clk);
      end
      par_v <= 1'b0;
   endtask : params

   task automatic run(input string name, input int n);
      int w;
      start <= 1'b1;
      @(posedge i_core_clk);
      start <= 1'b0;
      w = 0;
      while (running !== 1'b1) begin
         if (++w > 20) tmo("running");
         @(posedge i_core_clk);
      end
      feeding = 1'b1;
      fork
         begin
            feed(8, 1'b1);
            feed(n, 1'b0);
            // Valid dropped once, after both calls, not between them
            syn_v <= 1'b0;
            feeding = 1'b0;
         end
         params();
      join
      w = 0;
      while (eq.size() > 0) begin
         if (++w > 4 * DIV) tmo("drain");
         @(posedge i_core_clk);
      end
      $display("test %s done, %0d checks", name, total_checks);
   endtask : run

   initial begin
      i_core_clk = 1'b0;
      forever #2 i_core_clk = ~i_core_clk;
   end

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         dev_pr         <= 1'b0;
         flt_short_seen <= 1'b0;
      end else begin
         dev_pr <= 1'($urandom);
         if (flt_link.param_short === 1'b1) flt_short_seen <= 1'b1;
      end
   end

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         msr = 16'h0000;
         idx = 0;
         last_pcm = 16'h0000;
         eq.delete();
         aq.delete();
         pq.delete();
      end else begin
         if (syn_v && h_syn_rdy === 1'b1) begin
            d = add16(syn_d, mulr(msr, DEEMPH_COEF));
            msr = d;
            u = add16(d, d);
            eq.push_back({u[15:3], 3'h0});
            aq.push_back(alaw(u[15:3]));
         end
         if (par_v && h_par_rdy === 1'b1) pq.push_back(par_d);
         if (dev_pv === 1'b1 && dev_pr && pq.size() > 0)
            chk_word("param", pq.pop_front(), dev_pd);
         if (h_short === 1'b1) chk_bit("param_short", 1'b0, h_short);
         if (h_pv === 1'b1 && h_und === 1'b1) begin
            chk_word("held pcm", last_pcm, h_pcm);
         end else if (h_pv === 1'b1) begin
            chk_bit("frame_start", idx == 0, dev_fs);
            chk_word("pcm", eq.pop_front(), h_pcm);
            chk_word("alaw", {8'h00, aq.pop_front()}, {8'h00, h_alaw});
            last_pcm = h_pcm;
            idx = (idx + 1) % FRAME_SAMPLES;
         end
      end
   end

   initial begin
      i_rst = 1'b1;
      {start, par_v, syn_v, feeding} = 4'h0;
      par_d = 16'h0000;
      syn_d = 16'h0000;
      n_errors = 0;
      total_checks = 0;
      {flt_link.codec_reset_in, flt_link.par_valid} = 2'h0;
      flt_link.par_data = 16'h0000;
      flt_link.syn_valid = 1'b1;
      flt_link.synth_sample_in = 16'h1234;
      void'($urandom(32'h5813));
      repeat (20) @(posedge i_core_clk);
      i_rst <= 1'b0;
      flt_link.codec_reset_in <= 1'b1;
      repeat (CODEC_RESET_CYCLES) @(posedge i_core_clk);
      flt_link.codec_reset_in <= 1'b0;
      chk_bit("bit_exact", 1'b1, dev_be);
      chk_bit("homing bit_exact", 1'b0, flt_be);
      run("corner_random", 300);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      chk_word("pcm in reset", PCM_RESET, h_pcm);
      i_rst <= 1'b0;
      @(posedge i_core_clk);
      run("after_reset", 200);
      chk_bit("fault param_short", 1'b1, flt_short_seen);
      chk_bit("homing bit_exact later", 1'b1, flt_be);
      print_verdict();
   end
endmodule : sdos_tb_top
`default_nettype wire
